// *** design/temperature_sample_fifo.sv ***
// Temperature sample queue with its register set and almost-full flag.
// Assumes byte register accesses of one cycle each and samples from the conversion engine.
`timescale 1ns/1ns
`include "temp_fifo_defs.svh"

module temperature_sample_fifo (
    input  wire logic                          sys_clk,
    input  wire logic                          rst_n,
    input  wire logic                          clkEnable,
    input  wire logic                          sampleValid,
    input  wire logic [`TSF_SAMPLE_BITS-1:0]   sampleData,
    output logic                               sampleReady,
    input  wire temp_fifo_pkg::reg_req_t       regReq,
    output temp_fifo_pkg::reg_rsp_t            regRsp,
    output logic                               generalPinZeroOut,
    output logic                               generalPinZeroOe_n
);
    import temp_fifo_pkg::*;

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
        hit = (addr == target);
    endfunction

    function automatic logic [`TSF_INDEX_BITS-1:0] stepIndex(
        input logic [`TSF_INDEX_BITS-1:0] idx);
        stepIndex = (idx == `TSF_INDEX_MAX) ? `TSF_RESET_INDEX : idx + 1'b1;
    endfunction

    function automatic logic [7:0] padByte(input logic [`TSF_COUNT_BITS-1:0] v);
        padByte = '0;
        padByte[`TSF_COUNT_BITS-1:0] = v;
    endfunction

    logic [`TSF_SAMPLE_BITS-1:0] queueMem [0:`TSF_QUEUE_SLOTS-1];

    logic [`TSF_INDEX_BITS-1:0]  writeIndex;
    logic [`TSF_INDEX_BITS-1:0]  readIndex;
    logic [`TSF_INDEX_BITS-1:0]  lostWordCount;
    logic [`TSF_COUNT_BITS-1:0]  unreadWordCount;
    logic [`TSF_INDEX_BITS-1:0]  next_writeIndex;
    logic [`TSF_INDEX_BITS-1:0]  next_readIndex;
    logic [`TSF_INDEX_BITS-1:0]  next_lostWordCount;
    logic [`TSF_COUNT_BITS-1:0]  next_unreadWordCount;
    logic                        memWrite;

    logic [`TSF_INDEX_BITS-1:0]  almostFullThreshold;
    logic                        rolloverEnable;
    logic                        almostFullType;
    logic                        clearFlagOnDataRead;
    logic                        almostFullIntEnable;
    logic [`TSF_MODE_BITS-1:0]   pin0FunctionSelect;
    logic [`TSF_INDEX_BITS-1:0]  next_almostFullThreshold;
    logic                        next_rolloverEnable;
    logic                        next_almostFullType;
    logic                        next_clearFlagOnDataRead;
    logic                        next_almostFullIntEnable;
    logic [`TSF_MODE_BITS-1:0]   next_pin0FunctionSelect;

    logic                        almostFull;
    logic                        next_almostFull;
    logic [`TSF_COUNT_BITS-1:0]  flagLimit;
    logic                        condNow;
    logic                        condAfter;
    logic                        flagSet;
    logic                        flagClear;

    byte_phase_t                 bytePhase;
    byte_phase_t                 next_bytePhase;
    reg_rsp_t                    next_regRsp;

    logic                        statusRead;
    logic                        dataRead;
    logic                        popWord;
    logic                        flushWrite;
    logic                        readIndexWrite;
    logic                        behaviourWrite;
    logic                        queueFull;
    logic                        stageValid;
    logic [`TSF_SAMPLE_BITS-1:0] stageData;
    logic                        drainReady;
    logic                        push;
    logic [`TSF_SAMPLE_BITS-1:0] headWord;

    // Incoming samples wait here while the queue side is stalled
    sample_stage_fifo #(
        .WIDTH (`TSF_SAMPLE_BITS),
        .DEPTH (`TSF_STAGE_DEPTH)
    ) u_stage (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .clkEnable (clkEnable),
        .flush     (flushWrite),
        .inValid   (sampleValid),
        .inReady   (sampleReady),
        .inData    (sampleData),
        .outValid  (stageValid),
        .outReady  (drainReady),
        .outData   (stageData)
    );

    // Access decode
    always_comb begin
        statusRead     = regReq.rd && hit(regReq.addr, `TSF_ADDR_STATUS);
        dataRead       = regReq.rd && hit(regReq.addr, `TSF_ADDR_DATA);
        popWord        = dataRead && (bytePhase == BYTE_LOW);
        behaviourWrite = regReq.wr && hit(regReq.addr, `TSF_ADDR_BEHAV);
        flushWrite     = behaviourWrite && regReq.wdata[`TSF_BIT_FLUSH];
        readIndexWrite = regReq.wr && hit(regReq.addr, `TSF_ADDR_RD_IDX);
        drainReady     = !flushWrite && !readIndexWrite;
        push           = stageValid && drainReady;
        queueFull      = (unreadWordCount == `TSF_QUEUE_WORDS);
        headWord       = queueMem[readIndex];
    end

    // Indexes and counters
    always_comb begin
        next_writeIndex      = writeIndex;
        next_readIndex       = readIndex;
        next_lostWordCount   = lostWordCount;
        next_unreadWordCount = unreadWordCount;
        memWrite             = 1'b0;
        if (flushWrite) begin
            next_writeIndex      = `TSF_RESET_INDEX;
            next_readIndex       = `TSF_RESET_INDEX;
            next_lostWordCount   = `TSF_RESET_INDEX;
            next_unreadWordCount = `TSF_RESET_COUNT;
        end else begin
            if (readIndexWrite) begin
                next_readIndex = regReq.wdata[`TSF_INDEX_BITS-1:0];
            end else if (popWord) begin
                next_readIndex     = stepIndex(readIndex);
                next_lostWordCount = `TSF_RESET_INDEX;
                if (unreadWordCount != `TSF_RESET_COUNT) begin
                    next_unreadWordCount = unreadWordCount - 1'b1;
                end
            end
            if (push) begin
                if (!queueFull || popWord) begin
                    memWrite             = 1'b1;
                    next_writeIndex      = stepIndex(writeIndex);
                    next_unreadWordCount = next_unreadWordCount + 1'b1;
                end else begin
                    if (lostWordCount != `TSF_INDEX_MAX) begin
                        next_lostWordCount = lostWordCount + 1'b1;
                    end
                    if (rolloverEnable) begin
                        memWrite        = 1'b1;
                        next_writeIndex = stepIndex(writeIndex);
                        next_readIndex  = stepIndex(readIndex);
                    end
                end
            end
        end
    end

    // Almost-full flag
    always_comb begin
        flagLimit = `TSF_QUEUE_WORDS - {1'b0, almostFullThreshold};
        condNow   = (unreadWordCount >= flagLimit);
        condAfter = (next_unreadWordCount >= flagLimit);
        flagSet   = push && !flushWrite && condAfter
            && (!almostFullType || !condNow);
        flagClear = statusRead || (dataRead && clearFlagOnDataRead);
        if (flagSet) begin
            next_almostFull = 1'b1;
        end else if (flagClear) begin
            next_almostFull = 1'b0;
        end else begin
            next_almostFull = almostFull;
        end
    end

    // Configuration writes, byte phase and read data
    always_comb begin
        next_almostFullThreshold = almostFullThreshold;
        next_rolloverEnable      = rolloverEnable;
        next_almostFullType      = almostFullType;
        next_clearFlagOnDataRead = clearFlagOnDataRead;
        next_almostFullIntEnable = almostFullIntEnable;
        next_pin0FunctionSelect  = pin0FunctionSelect;
        if (regReq.wr && hit(regReq.addr, `TSF_ADDR_THRESH)) begin
            next_almostFullThreshold = regReq.wdata[`TSF_INDEX_BITS-1:0];
        end
        if (behaviourWrite) begin
            next_rolloverEnable      = regReq.wdata[`TSF_BIT_ROLLOVER];
            next_almostFullType      = regReq.wdata[`TSF_BIT_AF_TYPE];
            next_clearFlagOnDataRead = regReq.wdata[`TSF_BIT_STAT_CLR];
        end
        if (regReq.wr && hit(regReq.addr, `TSF_ADDR_INT_EN)) begin
            next_almostFullIntEnable = regReq.wdata[`TSF_BIT_AFULL_EN];
        end
        if (regReq.wr && hit(regReq.addr, `TSF_ADDR_PIN_SETUP)) begin
            next_pin0FunctionSelect = regReq.wdata[`TSF_MODE_BITS-1:0];
        end

        next_bytePhase = bytePhase;
        if (flushWrite || ((regReq.rd || regReq.wr) && !dataRead)) begin
            next_bytePhase = BYTE_HIGH;
        end else if (dataRead) begin
            unique case (bytePhase)
                BYTE_HIGH: next_bytePhase = BYTE_LOW;
                BYTE_LOW:  next_bytePhase = BYTE_HIGH;
            endcase
        end

        next_regRsp.valid = regReq.rd;
        next_regRsp.data  = `TSF_RESET_BYTE;
        if (regReq.rd) begin
            case (regReq.addr)
                `TSF_ADDR_STATUS:    next_regRsp.data[`TSF_BIT_AFULL] = almostFull;
                `TSF_ADDR_INT_EN:    next_regRsp.data[`TSF_BIT_AFULL_EN] = almostFullIntEnable;
                `TSF_ADDR_WR_IDX:    next_regRsp.data = padByte({1'b0, writeIndex});
                `TSF_ADDR_RD_IDX:    next_regRsp.data = padByte({1'b0, readIndex});
                `TSF_ADDR_LOST:      next_regRsp.data = padByte({1'b0, lostWordCount});
                `TSF_ADDR_UNREAD:    next_regRsp.data = padByte(unreadWordCount);
                `TSF_ADDR_DATA:      next_regRsp.data = (bytePhase == BYTE_HIGH)
                    ? headWord[`TSF_SAMPLE_BITS-1:8] : headWord[7:0];
                `TSF_ADDR_THRESH:    next_regRsp.data = padByte({1'b0, almostFullThreshold});
                `TSF_ADDR_BEHAV: begin
                    next_regRsp.data[`TSF_BIT_STAT_CLR] = clearFlagOnDataRead;
                    next_regRsp.data[`TSF_BIT_AF_TYPE]  = almostFullType;
                    next_regRsp.data[`TSF_BIT_ROLLOVER] = rolloverEnable;
                end
                `TSF_ADDR_PIN_SETUP: next_regRsp.data[`TSF_MODE_BITS-1:0] = pin0FunctionSelect;
                default:             next_regRsp.data = `TSF_RESET_BYTE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            writeIndex          <= `TSF_RESET_INDEX;
            readIndex           <= `TSF_RESET_INDEX;
            lostWordCount       <= `TSF_RESET_INDEX;
            unreadWordCount     <= `TSF_RESET_COUNT;
            almostFullThreshold <= `TSF_RESET_INDEX;
            rolloverEnable      <= 1'b0;
            almostFullType      <= 1'b0;
            clearFlagOnDataRead <= 1'b0;
            almostFullIntEnable <= 1'b0;
            pin0FunctionSelect  <= `TSF_RESET_MODE;
            almostFull          <= 1'b0;
            bytePhase           <= BYTE_HIGH;
            regRsp              <= '0;
        end else if (clkEnable) begin
            writeIndex          <= next_writeIndex;
            readIndex           <= next_readIndex;
            lostWordCount       <= next_lostWordCount;
            unreadWordCount     <= next_unreadWordCount;
            almostFullThreshold <= next_almostFullThreshold;
            rolloverEnable      <= next_rolloverEnable;
            almostFullType      <= next_almostFullType;
            clearFlagOnDataRead <= next_clearFlagOnDataRead;
            almostFullIntEnable <= next_almostFullIntEnable;
            pin0FunctionSelect  <= next_pin0FunctionSelect;
            almostFull          <= next_almostFull;
            bytePhase           <= next_bytePhase;
            regRsp              <= next_regRsp;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (clkEnable && memWrite) begin
            queueMem[writeIndex] <= stageData;
        end
    end

    // Open-drain interrupt on pin zero, pulled low while active
    always_comb begin
        generalPinZeroOut  = 1'b0;
        generalPinZeroOe_n = !(almostFull && almostFullIntEnable
            && (pin0FunctionSelect == `TSF_PIN_MODE_IRQ));
    end

    // Checks
    sequence s_high_byte;
        clkEnable && dataRead && (bytePhase == BYTE_HIGH);
    endsequence

    sequence s_low_byte;
        clkEnable && dataRead && (bytePhase == BYTE_LOW) && !flushWrite && !readIndexWrite;
    endsequence

    property p_word_pop;
        @(posedge sys_clk) disable iff (!rst_n)
        s_high_byte ##1 s_low_byte
            |=> (readIndex == stepIndex($past(readIndex))) && (lostWordCount == '0);
    endproperty
    a_word_pop: assert property (p_word_pop) else $error("word pop did not advance");

    property p_byte_order;
        @(posedge sys_clk) disable iff (!rst_n)
        s_high_byte |=> regRsp.valid && (regRsp.data == $past(headWord[15:8]));
    endproperty
    a_byte_order: assert property (p_byte_order) else $error("high byte not first");

    property p_write_step;
        @(posedge sys_clk) disable iff (!rst_n)
        clkEnable && memWrite && !flushWrite |=> writeIndex == stepIndex($past(writeIndex));
    endproperty
    a_write_step: assert property (p_write_step) else $error("write index did not step");

    property p_count_bound;
        @(posedge sys_clk) disable iff (!rst_n)
        unreadWordCount <= `TSF_QUEUE_WORDS;
    endproperty
    a_count_bound: assert property (p_count_bound) else $error("unread count above 32");

    property p_lost_saturate;
        @(posedge sys_clk) disable iff (!rst_n)
        clkEnable && !popWord && !flushWrite && (lostWordCount == `TSF_INDEX_MAX)
            |=> lostWordCount == `TSF_INDEX_MAX;
    endproperty
    a_lost_saturate: assert property (p_lost_saturate) else $error("lost count wrapped");

    property p_discard;
        @(posedge sys_clk) disable iff (!rst_n)
        clkEnable && push && queueFull && !popWord && !rolloverEnable
            |=> $stable(writeIndex) && (unreadWordCount == `TSF_QUEUE_WORDS);
    endproperty
    a_discard: assert property (p_discard) else $error("full queue accepted sample");

    property p_rollover;
        @(posedge sys_clk) disable iff (!rst_n)
        clkEnable && push && queueFull && !popWord && rolloverEnable
            |=> (readIndex == stepIndex($past(readIndex)))
                && (unreadWordCount == `TSF_QUEUE_WORDS);
    endproperty
    a_rollover: assert property (p_rollover) else $error("rollover lost alignment");

    property p_flush;
        @(posedge sys_clk) disable iff (!rst_n)
        clkEnable && flushWrite |=> (writeIndex == '0) && (readIndex == '0)
            && (unreadWordCount == '0) && (lostWordCount == '0);
    endproperty
    a_flush: assert property (p_flush) else $error("flush left state");

    property p_status_clear;
        @(posedge sys_clk) disable iff (!rst_n)
        clkEnable && statusRead && !flagSet |=> !almostFull;
    endproperty
    a_status_clear: assert property (p_status_clear) else $error("flag not cleared");

    property p_pin_drive;
        @(posedge sys_clk) disable iff (!rst_n)
        clkEnable && flagSet && almostFullIntEnable
            && (pin0FunctionSelect == `TSF_PIN_MODE_IRQ) && !regReq.wr
            |=> !generalPinZeroOe_n;
    endproperty
    a_pin_drive: assert property (p_pin_drive) else $error("pin zero not driven");
endmodule // temperature_sample_fifo

// *** include/temp_fifo_defs.svh ***
// Register offsets, field positions, reset values and sizes of the sample queue.
// Assumes byte-wide registers reached by a byte address on the device register port.
`ifndef TEMP_FIFO_DEFS_SVH
`define TEMP_FIFO_DEFS_SVH

`define TSF_ADDR_STATUS     8'h00
`define TSF_ADDR_INT_EN     8'h01
`define TSF_ADDR_WR_IDX     8'h04
`define TSF_ADDR_RD_IDX     8'h05
`define TSF_ADDR_LOST       8'h06
`define TSF_ADDR_UNREAD     8'h07
`define TSF_ADDR_DATA       8'h08
`define TSF_ADDR_THRESH     8'h09
`define TSF_ADDR_BEHAV      8'h0a
`define TSF_ADDR_PIN_SETUP  8'h20

`define TSF_BIT_AFULL       7
`define TSF_BIT_AFULL_EN    7
`define TSF_BIT_FLUSH       4
`define TSF_BIT_STAT_CLR    3
`define TSF_BIT_AF_TYPE     2
`define TSF_BIT_ROLLOVER    1

`define TSF_SAMPLE_BITS     16
`define TSF_INDEX_BITS      5
`define TSF_COUNT_BITS      6
`define TSF_MODE_BITS       2
`define TSF_QUEUE_SLOTS     32
`define TSF_QUEUE_WORDS     6'h20
`define TSF_INDEX_MAX       5'h1f
`define TSF_PIN_MODE_IRQ    2'h3
`define TSF_STAGE_DEPTH     8

`define TSF_RESET_BYTE      8'h00
`define TSF_RESET_INDEX     5'h00
`define TSF_RESET_COUNT     6'h00
`define TSF_RESET_MODE      2'h0

`endif

// *** include/temp_fifo_pkg.sv ***
// Types shared by the sample queue and its register port.
// Assumes the constants header is on the include path.
`include "temp_fifo_defs.svh"

package temp_fifo_pkg;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } reg_rsp_t;

    typedef enum logic {
        BYTE_HIGH,
        BYTE_LOW
    } byte_phase_t;

endpackage

// *** design/sample_stage_fifo.sv ***
// Small synchronous FIFO that buffers incoming samples ahead of the queue.
// Assumes one clock, a clock enable that freezes it, and a synchronous flush.
`timescale 1ns/1ns

module sample_stage_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic             clkEnable,
    input  wire logic             flush,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [0:DEPTH-1];
    logic [PW:0]      head;
    logic [PW:0]      tail;
    logic [PW:0]      next_head;
    logic [PW:0]      next_tail;
    logic             doPush;
    logic             doPop;

    always_comb begin
        outValid  = (head != tail);
        inReady   = !((head[PW] != tail[PW]) && (head[PW-1:0] == tail[PW-1:0]));
        doPush    = inValid && inReady && !flush;
        doPop     = outValid && outReady && !flush;
        outData   = store[head[PW-1:0]];
        next_head = flush ? '0 : (doPop ? head + 1'b1 : head);
        next_tail = flush ? '0 : (doPush ? tail + 1'b1 : tail);
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            head <= '0;
            tail <= '0;
        end else if (clkEnable) begin
            head <= next_head;
            tail <= next_tail;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (clkEnable && doPush) begin
            store[tail[PW-1:0]] <= inData;
        end
    end
endmodule // sample_stage_fifo

// *** verif/sample_source.sv ***
// Conversion-side model offering samples on a valid/ready handshake.
// Assumes the queue takes a word on a rising edge while ready is high.
`timescale 1ns/1ns

module sample_source (
    input  wire logic        sys_clk,
    input  wire logic        ready,
    output logic             valid,
    output logic [15:0]      data
);
    initial begin
        valid = 1'b0;
        data  = 16'h0000;
    end

    // Offers n words from base, each held until taken or until 50 cycles pass without ready
    task automatic send(input int n, input logic [15:0] base, output logic ok);
        int tries;
        ok = 1'b1;
        for (int i = 0; i < n; i++) begin
            data  = base + 16'(i);
            valid = 1'b1;
            tries = 0;
            do begin
                @(negedge sys_clk);
                tries++;
            end while (ready !== 1'b1 && tries < 50);
            if (tries >= 50) ok = 1'b0;
            @(posedge sys_clk);
            #1;
        end
        valid = 1'b0;
        data  = ~data;
    endtask
endmodule // sample_source

// *** verif/temperature_sample_fifo_test.sv ***
// Self-checking bench for the temperature sample queue.
// Assumes the queue design files and the sample source model are compiled first.
`timescale 1ns/1ns
`include "temp_fifo_defs.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end

module temperature_sample_fifo_test;
    import temp_fifo_pkg::*;
    typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
    logic        sys_clk, rst_n, sampleValid, sampleReady, pinOut, pinOe_n, ok;
    logic        clkEn;
    logic [15:0] sampleData, w;
    logic [7:0]  rb;
    reg_req_t    regReq;
    reg_rsp_t    regRsp;
    int          miscompares, checks_done;
    logic [7:0]  zeroRegs [6] = '{8'h00, 8'h04, 8'h05, 8'h06, 8'h07, 8'h0a};
    row_t        rows [9] = '{
        '{8'h09, 8'hff, 8'h1f},
        '{8'h05, 8'h07, 8'h07},
        '{8'h04, 8'hff, 8'h00},
        '{8'h06, 8'hff, 8'h00},
        '{8'h07, 8'hff, 8'h00},
        '{8'h3c, 8'h55, 8'h00},
        '{8'h01, 8'hff, 8'h80},
        '{8'h20, 8'hff, 8'h03},
        '{8'h0a, 8'hff, 8'h0e}};

    temperature_sample_fifo DUT (.sys_clk(sys_clk), .rst_n(rst_n), .clkEnable(clkEn),
        .sampleValid(sampleValid), .sampleData(sampleData), .sampleReady(sampleReady),
        .regReq(regReq), .regRsp(regRsp), .generalPinZeroOut(pinOut),
        .generalPinZeroOe_n(pinOe_n));
    sample_source src (.sys_clk(sys_clk), .ready(sampleReady), .valid(sampleValid),
        .data(sampleData));

    task automatic results;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
        regReq = '{1'b0, 1'b1, a, d};
        @(posedge sys_clk); #1;
        regReq = '0;
        @(posedge sys_clk); #1;
    endtask
    task automatic check(input logic [7:0] a, input logic [7:0] e);
        regReq = '{1'b1, 1'b0, a, 8'h00};
        @(posedge sys_clk); #1;
        `CHK(regRsp.valid, 1'b1)
        `CHK(regRsp.data, e)
        regReq = '0;
        @(posedge sys_clk); #1;
    endtask
    // Two-byte burst at the data register, high byte first
    task automatic checkWord(input logic [15:0] e);
        regReq = '{1'b1, 1'b0, 8'h08, 8'h00};
        @(posedge sys_clk); #1;
        w[15:8] = regRsp.data;
        @(posedge sys_clk); #1;
        w[7:0] = regRsp.data;
        regReq = '0;
        `CHK(w, e)
        @(posedge sys_clk); #1;
    endtask
    task automatic push(input int n, input logic [15:0] base);
        src.send(n, base, ok);
        `CHK(ok, 1'b1)
        repeat (3) @(posedge sys_clk);
        #1;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    initial begin
        #2000000;
        miscompares++;
        results();
    end
    initial begin
        rst_n = 1'b0;
        clkEn = 1'b1;
        regReq = '0;
        repeat (8) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        `CHK(pinOe_n, 1'b1)
        foreach (zeroRegs[i]) check(zeroRegs[i], 8'h00);
        check(8'h09, 8'h00);
        foreach (rows[i]) begin
            regWrite(rows[i].a, rows[i].d);
            check(rows[i].a, rows[i].e);
        end
        check(8'h05, 8'h00);
        regWrite(8'h0a, 8'h00);
        regWrite(8'h09, 8'h02);
        push(3, 16'h1234);
        check(8'h04, 8'h03);
        check(8'h07, 8'h03);
        checkWord(16'h1234);
        check(8'h05, 8'h01);
        check(8'h07, 8'h02);
        checkWord(16'h1235);
        checkWord(16'h1236);
        push(34, 16'h0100);
        check(8'h06, 8'h02);
        check(8'h07, 8'h20);
        check(8'h04, 8'h03);
        `CHK(pinOe_n, 1'b0)
        `CHK(pinOut, 1'b0)
        check(8'h00, 8'h80);
        check(8'h00, 8'h00);
        `CHK(pinOe_n, 1'b1)
        checkWord(16'h0100);
        check(8'h06, 8'h00);
        check(8'h07, 8'h1f);
        regWrite(8'h0a, 8'h02);
        push(2, 16'h0200);
        check(8'h07, 8'h20);
        check(8'h06, 8'h01);
        check(8'h05, 8'h05);
        checkWord(16'h0102);
        check(8'h00, 8'h80);
        regWrite(8'h0a, 8'h0c);
        push(1, 16'h0300);
        check(8'h00, 8'h00);
        checkWord(16'h0103);
        checkWord(16'h0104);
        checkWord(16'h0105);
        push(1, 16'h0301);
        `CHK(pinOe_n, 1'b0)
        checkWord(16'h0106);
        check(8'h00, 8'h00);
        regWrite(8'h05, 8'h09);
        checkWord(16'h0106);
        regWrite(8'h0a, 8'h10);
        foreach (zeroRegs[i]) check(zeroRegs[i], 8'h00);
        clkEn = 1'b0;
        regWrite(8'h05, 8'h03);
        clkEn = 1'b1;
        check(8'h05, 8'h00);
        push(65, 16'h0400);
        check(8'h06, 8'h1f);
        rst_n = 1'b0;
        @(posedge sys_clk); #1;
        `CHK(pinOe_n, 1'b1)
        rst_n = 1'b1;
        check(8'h07, 8'h00);
        results();
    end
endmodule // temperature_sample_fifo_test
